/* File: rtl/iopc_checksum.sv */
// Purpose: modulo 256 sum of eight frame bytes
// Assumes: bytes packed most significant first
// Notes: purely combinational
`timescale 1ns/1ps
module iopc_checksum (
    // frame body
    input wire logic [63:0] bytes_i,
    // sum
    output logic [7:0] sum_o
);
    import iopc_pkg::*;
    logic [7:0] acc;
    always_comb begin
        acc = 8'h00;
        for (int i = 0; i < FRAME_BYTES - 1; i++) begin
            acc = acc + bytes_i[i*8 +: 8];
        end
        sum_o = acc;
    end
endmodule : iopc_checksum

/* File: rtl/iopc_input_select.sv */
// Purpose: picks the value that a get-input command returns
// Assumes: analog results already converted, 12 bit
// Notes: combinational; unknown ports flag invalid
`timescale 1ns/1ps
module iopc_input_select (
    // selection
    input wire logic [7:0] port_i,
    input wire logic [7:0] bank_i,
    // sources
    input wire logic [7:0] din_i,
    input wire logic [7:0] dout_i,
    input wire logic [11:0] adc_zero_i,
    input wire logic [11:0] adc_four_i,
    input wire logic [11:0] supply_i,
    input wire logic [35:0] temp_i,
    // result
    output logic [31:0] value_o,
    output logic valid_o
);
    import iopc_pkg::*;
    logic [7:0] tidx;
    always_comb begin
        value_o = 32'h00000000;
        valid_o = 1'b1;
        tidx = port_i - PORT_TEMP_FIRST;
        if (bank_i == BANK_ZERO) begin
            if (port_i == PORT_ALL) begin
                value_o = {24'h000000, din_i};
            end else if (port_i < 8'h08) begin
                value_o = {31'h00000000, din_i[port_i[2:0]]};
            end else begin
                valid_o = 1'b0;
            end
        end else if (bank_i == BANK_ONE) begin
            if (port_i == PORT_ANALOG_ZERO) begin
                value_o = {20'h00000, adc_zero_i};
            end else if (port_i == PORT_ANALOG_FOUR) begin
                value_o = {20'h00000, adc_four_i};
            end else if (port_i == PORT_SUPPLY) begin
                value_o = {20'h00000, supply_i};
            end else if (port_i >= PORT_TEMP_FIRST && port_i <= PORT_TEMP_LAST) begin
                value_o = {20'h00000, temp_i[tidx[1:0]*12 +: 12]};
            end else begin
                valid_o = 1'b0;
            end
        end else if (bank_i == BANK_TWO) begin
            if (port_i == PORT_ALL) begin
                value_o = {24'h000000, dout_i};
            end else if (port_i < 8'h08) begin
                value_o = {31'h00000000, dout_i[port_i[2:0]]};
            end else begin
                valid_o = 1'b0;
            end
        end else begin
            valid_o = 1'b0;
        end
    end
endmodule : iopc_input_select

/* File: rtl/iopc_pkg.sv */
// Purpose: shared constants for the io port command unit
// Assumes: 100 MHz clock, APB register access
// Notes: frame layout, command codes, register offsets
package iopc_pkg;
    localparam logic [7:0] CMD_SET_OUTPUT = 8'h0E;
    localparam logic [7:0] CMD_GET_INPUT = 8'h0F;
    localparam logic [7:0] STATUS_OK = 8'h64;
    localparam logic [7:0] STATUS_BAD_CHECKSUM = 8'h01;
    localparam logic [7:0] STATUS_BAD_VALUE = 8'h04;
    localparam logic [7:0] STATUS_BAD_TYPE = 8'h03;
    localparam logic [7:0] STATUS_BAD_CMD = 8'h02;
    localparam logic [7:0] BANK_ZERO = 8'h00;
    localparam logic [7:0] BANK_ONE = 8'h01;
    localparam logic [7:0] BANK_TWO = 8'h02;
    localparam logic [7:0] PORT_ALL = 8'hFF;
    localparam logic [7:0] PORT_SUPPLY = 8'h08;
    localparam logic [7:0] PORT_TEMP_FIRST = 8'h09;
    localparam logic [7:0] PORT_TEMP_LAST = 8'h0B;
    localparam logic [7:0] PORT_ANALOG_ZERO = 8'h00;
    localparam logic [7:0] PORT_ANALOG_FOUR = 8'h04;
    localparam logic [31:0] VALUE_FROM_ACCU = 32'hFFFFFFFF;
    localparam int FRAME_BYTES = 9;
    localparam logic [1:0] PULLUP_RESET = 2'h3;
    localparam logic [7:0] OUTPUT_RESET = 8'h00;
    localparam logic [7:0] HOST_ADDR_RESET = 8'h02;
    localparam logic [7:0] MODULE_ADDR_RESET = 8'h01;
    // register byte offsets
    localparam logic [7:0] REG_CMD_LO = 8'h00;
    localparam logic [7:0] REG_CMD_HI = 8'h04;
    localparam logic [7:0] REG_CTRL = 8'h08;
    localparam logic [7:0] REG_REPLY_LO = 8'h0C;
    localparam logic [7:0] REG_REPLY_HI = 8'h10;
    localparam logic [7:0] REG_STATUS = 8'h14;
    localparam logic [7:0] REG_ACCU = 8'h18;
    localparam logic [7:0] REG_OUTPUTS = 8'h1C;
    localparam logic [7:0] REG_ADDR = 8'h20;
    // control and status bit positions
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_STANDALONE_BIT = 1;
    localparam int STAT_BUSY_BIT = 0;
    localparam int STAT_DONE_BIT = 1;
endpackage : iopc_pkg

/* File: rtl/iopc_top.sv */
// Purpose: io port command unit: set-output and get-input over nine-byte frames
// Assumes: frames written by software over APB; analog values supplied converted
// Notes: one command at a time; reply readable when done is set
//
// Functional notes
// - set-output bank 2 drives the typed output to value 0/1, replies 100
// - bank 2 holds eight outputs, ports 0 to 7, values 0 or 1 only
// - port 255 bank 2 writes all eight outputs from value bits 7:0
// - value -1 on all-outputs write takes the pattern from the accumulator
// - port 0 bank 0 sets pull-up groups: bit0 motors 0-2, bit1 motors 3-5
// - both pull-up enables are set after reset
// - get-input reads the line chosen by type as port and bank 0/1/2
// - digital reads give 0 or 1, converter reads give 0 to 4095
// - in standalone mode get-input copies the value into the accumulator, except port 255 bank 0, which loads its low byte
// - in direct mode get-input leaves the accumulator unchanged, except port 255 bank 0, which loads its low byte
// - bank 0 returns eight digital inputs; ports 0 and 4 are analog-capable
// - port 255 bank 0 reads all inputs into accumulator low byte
// - bank 1: ports 0,4 converter, 8 supply in 0.1 V, 9-11 temperatures
// - bank 2 reads return the driven state of each output
// - get-input reply has status 100 and the value in the value field
// - reply: host addr, target addr, status, instruction, value msb first, checksum
`timescale 1ns/1ps
module iopc_top (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // io lines
    input wire logic [7:0] digital_inputs_i,
    input wire logic [11:0] analog_zero_i,
    input wire logic [11:0] analog_four_i,
    input wire logic [11:0] supply_tenths_i,
    input wire logic [35:0] temperatures_i,
    output logic [7:0] gp_outputs_o,
    output logic [1:0] pullup_enable_o
);
    import iopc_pkg::*;

    // ****************************************
    // state
    // ****************************************
    typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_DONE} iopc_state_t;
    iopc_state_t state_q, state_d;
    logic [63:0] cmd_q, cmd_d;
    logic [71:0] reply_q, reply_d;
    logic [31:0] accu_q, accu_d;
    logic [7:0] outputs_q, outputs_d;
    logic [1:0] pullup_q, pullup_d;
    logic [7:0] host_addr_q, host_addr_d;
    logic [7:0] mod_addr_q, mod_addr_d;
    logic standalone_q, standalone_d;
    logic [7:0] cmd_csum_q, cmd_csum_d;
    logic [31:0] prdata_q, prdata_d;

    // ****************************************
    // frame fields
    // ****************************************
    logic [7:0] f_target, f_instr, f_type, f_bank, rx_sum, tx_sum;
    logic [31:0] f_value, sel_value;
    logic sel_valid;
    logic [63:0] tx_body;
    assign f_target = cmd_q[63:56];
    assign f_instr = cmd_q[55:48];
    assign f_type = cmd_q[47:40];
    assign f_bank = cmd_q[39:32];
    assign f_value = cmd_q[31:0];

    iopc_checksum u_rx_sum (
        .bytes_i(cmd_q),
        .sum_o(rx_sum)
    );

    iopc_input_select u_sel (
        .port_i(f_type),
        .bank_i(f_bank),
        .din_i(digital_inputs_i),
        .dout_i(outputs_q),
        .adc_zero_i(analog_zero_i),
        .adc_four_i(analog_four_i),
        .supply_i(supply_tenths_i),
        .temp_i(temperatures_i),
        .value_o(sel_value),
        .valid_o(sel_valid)
    );

    // ****************************************
    // apb access
    // ****************************************
    logic apb_wr, apb_rd, addr_ok;
    assign apb_wr = psel_i && penable_i && pwrite_i;
    assign apb_rd = psel_i && !penable_i && !pwrite_i;
    assign pready_o = 1'b1;
    assign addr_ok = (paddr_i <= REG_ADDR) && (paddr_i[1:0] == 2'h0);
    assign pslverr_o = psel_i && penable_i && !addr_ok;
    assign prdata_o = prdata_q;

    always_comb begin
        prdata_d = prdata_q;
        if (apb_rd) begin
            if (paddr_i == REG_CMD_LO) begin
                prdata_d = cmd_q[31:0];
            end else if (paddr_i == REG_CMD_HI) begin
                prdata_d = cmd_q[63:32];
            end else if (paddr_i == REG_CTRL) begin
                prdata_d = {30'h00000000, standalone_q, 1'b0};
            end else if (paddr_i == REG_REPLY_LO) begin
                // reply is {host, target, status, instr, value, checksum}
                prdata_d = reply_q[39:8];
            end else if (paddr_i == REG_REPLY_HI) begin
                prdata_d = reply_q[71:40];
            end else if (paddr_i == REG_STATUS) begin
                prdata_d = {16'h0000, reply_q[7:0], 6'h00,
                            state_q == ST_DONE, state_q == ST_EXEC};
            end else if (paddr_i == REG_ACCU) begin
                prdata_d = accu_q;
            end else if (paddr_i == REG_OUTPUTS) begin
                prdata_d = {22'h000000, pullup_q, outputs_q};
            end else if (paddr_i == REG_ADDR) begin
                prdata_d = {16'h0000, host_addr_q, mod_addr_q};
            end else begin
                prdata_d = 32'h00000000;
            end
        end
    end

    // ****************************************
    // command execution
    // ****************************************
    logic [7:0] out_pattern;
    logic [7:0] r_status;
    logic [31:0] r_value;
    always_comb begin
        state_d = state_q;
        cmd_d = cmd_q;
        reply_d = reply_q;
        accu_d = accu_q;
        outputs_d = outputs_q;
        pullup_d = pullup_q;
        host_addr_d = host_addr_q;
        mod_addr_d = mod_addr_q;
        standalone_d = standalone_q;
        cmd_csum_d = cmd_csum_q;
        r_status = STATUS_OK;
        r_value = 32'h00000000;
        tx_body = 64'h0;
        tx_sum = 8'h00;
        out_pattern = (f_value == VALUE_FROM_ACCU) ? accu_q[7:0] : f_value[7:0];
        if (apb_wr && state_q != ST_EXEC) begin
            if (paddr_i == REG_CMD_LO) begin
                cmd_d[31:0] = pwdata_i;
            end else if (paddr_i == REG_CMD_HI) begin
                cmd_d[63:32] = pwdata_i;
            end else if (paddr_i == REG_CTRL) begin
                standalone_d = pwdata_i[CTRL_STANDALONE_BIT];
                cmd_csum_d = pwdata_i[15:8];
                if (pwdata_i[CTRL_GO_BIT]) begin
                    state_d = ST_EXEC;
                end
            end else if (paddr_i == REG_ACCU) begin
                accu_d = pwdata_i;
            end else if (paddr_i == REG_ADDR) begin
                mod_addr_d = pwdata_i[7:0];
                host_addr_d = pwdata_i[15:8];
            end
        end
        if (state_q == ST_EXEC) begin
            if (rx_sum != cmd_csum_q) begin
                r_status = STATUS_BAD_CHECKSUM;
            end else if (f_instr == CMD_SET_OUTPUT) begin
                if (f_bank == BANK_TWO && f_type == PORT_ALL) begin
                    outputs_d = out_pattern;
                end else if (f_bank == BANK_TWO && f_type < 8'h08) begin
                    if (f_value > 32'h1) begin
                        r_status = STATUS_BAD_VALUE;
                    end else begin
                        outputs_d[f_type[2:0]] = f_value[0];
                    end
                end else if (f_bank == BANK_ZERO && f_type == 8'h00) begin
                    pullup_d = f_value[1:0];
                end else begin
                    r_status = STATUS_BAD_TYPE;
                end
            end else if (f_instr == CMD_GET_INPUT) begin
                if (sel_valid) begin
                    r_value = sel_value;
                    if (standalone_q) begin
                        accu_d = sel_value;
                    end
                    if (f_bank == BANK_ZERO && f_type == PORT_ALL) begin
                        accu_d = {accu_q[31:8], sel_value[7:0]};
                    end
                    // direct mode leaves the accumulator alone except on port 255 bank 0
                end else begin
                    r_status = STATUS_BAD_TYPE;
                end
            end else begin
                r_status = STATUS_BAD_CMD;
            end
            tx_body = {host_addr_q, f_target, r_status, f_instr, r_value};
            for (int i = 0; i < FRAME_BYTES - 1; i++) begin
                tx_sum = tx_sum + tx_body[i*8 +: 8];
            end
            reply_d = {tx_body, tx_sum};
            state_d = ST_DONE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            state_q <= ST_IDLE;
            cmd_q <= 64'h0;
            reply_q <= 72'h0;
            accu_q <= 32'h00000000;
            outputs_q <= OUTPUT_RESET;
            pullup_q <= PULLUP_RESET;
            host_addr_q <= HOST_ADDR_RESET;
            mod_addr_q <= MODULE_ADDR_RESET;
            standalone_q <= 1'b0;
            cmd_csum_q <= 8'h00;
            prdata_q <= 32'h00000000;
        end else begin
            state_q <= state_d;
            cmd_q <= cmd_d;
            reply_q <= reply_d;
            accu_q <= accu_d;
            outputs_q <= outputs_d;
            pullup_q <= pullup_d;
            host_addr_q <= host_addr_d;
            mod_addr_q <= mod_addr_d;
            standalone_q <= standalone_d;
            cmd_csum_q <= cmd_csum_d;
            prdata_q <= prdata_d;
        end
    end

    assign gp_outputs_o = outputs_q;
    assign pullup_enable_o = pullup_q;
endmodule : iopc_top

/* File: verif/iopc_asserts.sv */
// Purpose: port-level checks for the io port command unit
// Assumes: bound to iopc_top, single clock domain
// Notes: output changes must trace back to a go write
`timescale 1ns/1ps
module iopc_asserts (
    // clock and reset
    input wire logic clk_i,
    input wire logic sys_rst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [31:0] prdata_o,
    input wire logic pready_o,
    input wire logic pslverr_o,
    // io lines
    input wire logic [7:0] gp_outputs_o,
    input wire logic [1:0] pullup_enable_o
);
    import iopc_pkg::*;
    // ****
    // checks
    // ****
    logic go_w;
    logic rd_out_w;
    assign go_w = psel_i & penable_i & pwrite_i & (paddr_i == REG_CTRL) & pwdata_i[CTRL_GO_BIT];
    assign rd_out_w = psel_i & penable_i & ~pwrite_i & (paddr_i == REG_OUTPUTS);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    a_pullup_reset: assert property ($past(sys_rst_i) |-> pullup_enable_o == PULLUP_RESET)
        else $error("pull-ups not enabled after reset");
    a_out_reset: assert property ($past(sys_rst_i) |-> gp_outputs_o == OUTPUT_RESET)
        else $error("outputs not cleared after reset");
    a_rdata_reset: assert property ($past(sys_rst_i) |-> prdata_o == 32'h00000000)
        else $error("read data not cleared after reset");
    a_addr_err: assert property (psel_i && penable_i |->
        pslverr_o == (paddr_i > REG_ADDR || paddr_i[1:0] != 2'h0))
        else $error("slave error does not match address");
    a_ready_high: assert property (psel_i && penable_i |-> pready_o)
        else $error("access phase not ready");
    a_out_cause: assert property ($changed(gp_outputs_o) |-> $past(go_w) || $past(go_w, 2))
        else $error("outputs changed without a command");
    a_pull_cause: assert property ($changed(pullup_enable_o) |-> $past(go_w) || $past(go_w, 2))
        else $error("pull-ups changed without a command");
    a_out_readback: assert property (rd_out_w && $stable(gp_outputs_o) && $stable(pullup_enable_o)
        |-> prdata_o[9:0] == {pullup_enable_o, gp_outputs_o})
        else $error("output readback differs from driven state");
endmodule : iopc_asserts

/* File: verif/iopc_host_model.sv */
// Purpose: host model issuing command frames over apb
// Assumes: request held until pready is sampled high
// Notes: released lines other than pwrite show the inverse of their last value
`timescale 1ns/1ps
module iopc_host_model (
    // clock
    input wire logic clk_i,
    // apb master side
    output logic psel_o,
    output logic penable_o,
    output logic pwrite_o,
    output logic [7:0] paddr_o,
    output logic [31:0] pwdata_o,
    input wire logic [31:0] prdata_i,
    input wire logic pready_i,
    input wire logic pslverr_i
);
    import iopc_pkg::*;
    initial begin
        psel_o = 1'b0;
        penable_o = 1'b0;
        pwrite_o = 1'b0;
        paddr_o = 8'h00;
        pwdata_o = 32'h00000000;
    end
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        @(posedge clk_i);
        psel_o <= 1'b1;
        penable_o <= 1'b0;
        pwrite_o <= wr;
        paddr_o <= a;
        pwdata_o <= wd;
        @(posedge clk_i);
        penable_o <= 1'b1;
        @(posedge clk_i);
        while (pready_i !== 1'b1) @(posedge clk_i);
        rd = prdata_i;
        err = pslverr_i;
        psel_o <= 1'b0;
        penable_o <= 1'b0;
        paddr_o <= ~a;
        pwdata_o <= ~wd;
    endtask : apb
    // frame goes out as target, instruction, type, bank, value msb first, checksum
    task automatic cmd(input logic [7:0] ins, typ, bnk, input logic [31:0] val,
                       input logic sa, bad);
        logic [31:0] rd;
        logic err;
        logic [7:0] cs;
        cs = MODULE_ADDR_RESET + ins + typ + bnk + val[31:24] + val[23:16] + val[15:8] + val[7:0];
        if (bad) cs = cs + 8'h01;
        apb(1'b1, REG_CMD_HI, {MODULE_ADDR_RESET, ins, typ, bnk}, rd, err);
        apb(1'b1, REG_CMD_LO, val, rd, err);
        apb(1'b1, REG_CTRL, {16'h0000, cs, 6'h00, sa, 1'b1}, rd, err);
    endtask : cmd
endmodule : iopc_host_model

/* File: verif/tb_io_port_command_unit.sv */
// Purpose: self-checking bench for the io port command unit
// Assumes: host model drives apb, bench drives io lines
// Notes: fixed seed, corner values mixed with random ones
`timescale 1ns/1ps
module tb_io_port_command_unit;
    import iopc_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr, din, gp_outputs, gp_m;
    logic [31:0] pwdata, prdata, rd;
    logic [11:0] a0, a4, sup;
    logic [35:0] tmp;
    logic [1:0] pullups;
    int seed = 32'h2ef31693;
    int n_fail = 0;
    int total_checks = 0;
    always #5 clk_i = ~clk_i;
    iopc_top dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .digital_inputs_i(din), .analog_zero_i(a0),
        .analog_four_i(a4), .supply_tenths_i(sup), .temperatures_i(tmp),
        .gp_outputs_o(gp_outputs), .pullup_enable_o(pullups));
    iopc_host_model host (.clk_i(clk_i), .psel_o(psel), .penable_o(penable), .pwrite_o(pwrite),
        .paddr_o(paddr), .pwdata_o(pwdata), .prdata_i(prdata), .pready_i(pready),
        .pslverr_i(pslverr));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    function automatic logic [31:0] exp_in(input logic [7:0] bnk, input logic [7:0] p);
        if (bnk == BANK_ZERO) return (p == PORT_ALL) ? {24'h0, din} : {31'h0, din[p[2:0]]};
        if (bnk == BANK_TWO) return (p == PORT_ALL) ? {24'h0, gp_m} : {31'h0, gp_m[p[2:0]]};
        if (p == PORT_ANALOG_ZERO) return {20'h0, a0};
        if (p == PORT_ANALOG_FOUR) return {20'h0, a4};
        if (p == PORT_SUPPLY) return {20'h0, sup};
        return {20'h0, tmp[(p - PORT_TEMP_FIRST) * 12 +: 12]};
    endfunction : exp_in
    task automatic run(input logic [7:0] ins, typ, bnk, input logic [31:0] val,
                       input logic sa, bad, input logic [7:0] st);
        logic [31:0] s, hi, lo;
        logic [7:0] cs;
        int k;
        host.cmd(ins, typ, bnk, val, sa, bad);
        k = 0;
        s = 32'h0;
        while (s[STAT_DONE_BIT] !== 1'b1 && k < 20) begin
            host.apb(1'b0, REG_STATUS, 32'h0, s, err);
            k++;
        end
        host.apb(1'b0, REG_REPLY_HI, 32'h0, hi, err);
        host.apb(1'b0, REG_REPLY_LO, 32'h0, lo, err);
        cs = hi[31:24] + hi[23:16] + hi[15:8] + hi[7:0] + lo[31:24] + lo[23:16] + lo[15:8] + lo[7:0];
        chk({31'h0, s[STAT_DONE_BIT]}, 32'h1);
        chk(hi, {HOST_ADDR_RESET, MODULE_ADDR_RESET, st, ins});
        chk({24'h0, s[15:8]}, {24'h0, cs});
        if (ins == CMD_GET_INPUT && st == STATUS_OK) chk(lo, exp_in(bnk, typ));
    endtask : run
    initial begin
        #100000;
        n_fail++;
        stop_test();
    end
    initial begin
        logic [31:0] v;
        logic [95:0] rr;
        din = 8'h00;
        a0 = 12'h000;
        a4 = 12'h000;
        sup = 12'h000;
        tmp = 36'h0;
        gp_m = OUTPUT_RESET;
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        @(posedge clk_i);
        chk({30'h0, pullups}, {30'h0, PULLUP_RESET});
        host.apb(1'b0, REG_OUTPUTS, 32'h0, rd, err);
        chk(rd, {22'h0, PULLUP_RESET, OUTPUT_RESET});
        for (int p = 0; p < 8; p++) begin
            v = $random(seed) & 32'h1;
            run(CMD_SET_OUTPUT, p[7:0], BANK_TWO, v, 1'b0, 1'b0, STATUS_OK);
            gp_m[p] = v[0];
            chk({24'h0, gp_outputs}, {24'h0, gp_m});
            run(CMD_GET_INPUT, p[7:0], BANK_TWO, 32'h0, 1'b0, 1'b0, STATUS_OK);
        end
        run(CMD_SET_OUTPUT, 8'h03, BANK_TWO, 32'h2, 1'b0, 1'b0, STATUS_BAD_VALUE);
        chk({24'h0, gp_outputs}, {24'h0, gp_m});
        for (int i = 0; i < 4; i++) begin
            v = (i == 0) ? 32'h0 : (i == 1) ? 32'hFF : $random(seed) & 32'hFF;
            run(CMD_SET_OUTPUT, PORT_ALL, BANK_TWO, v, 1'b0, 1'b0, STATUS_OK);
            gp_m = v[7:0];
            chk({24'h0, gp_outputs}, {24'h0, gp_m});
        end
        v = $random(seed);
        host.apb(1'b1, REG_ACCU, v, rd, err);
        run(CMD_SET_OUTPUT, PORT_ALL, BANK_TWO, VALUE_FROM_ACCU, 1'b0, 1'b0, STATUS_OK);
        gp_m = v[7:0];
        chk({24'h0, gp_outputs}, {24'h0, gp_m});
        for (int i = 0; i < 4; i++) begin
            run(CMD_SET_OUTPUT, 8'h00, BANK_ZERO, 32'(i), 1'b0, 1'b0, STATUS_OK);
            chk({30'h0, pullups}, 32'(i));
        end
        rr = {$random(seed), $random(seed), $random(seed)};
        @(posedge clk_i);
        din <= rr[7:0];
        a0 <= rr[19:8];
        a4 <= rr[31:20];
        sup <= rr[43:32];
        tmp <= rr[79:44];
        host.apb(1'b1, REG_ACCU, 32'h0, rd, err);
        for (int p = 0; p < 8; p++) begin
            run(CMD_GET_INPUT, p[7:0], BANK_ZERO, 32'h0, 1'b0, 1'b0, STATUS_OK);
        end
        run(CMD_GET_INPUT, PORT_ALL, BANK_ZERO, 32'h0, 1'b0, 1'b0, STATUS_OK);
        host.apb(1'b0, REG_ACCU, 32'h0, rd, err);
        chk(rd, {24'h0, din});
        host.apb(1'b1, REG_ACCU, 32'hA5A55A5A, rd, err);
        for (int i = 0; i < 6; i++) begin
            v = (i < 2) ? 32'(i * 4) : 32'(i + 6);
            run(CMD_GET_INPUT, v[7:0], BANK_ONE, 32'h0, 1'b0, 1'b0, STATUS_OK);
        end
        host.apb(1'b0, REG_ACCU, 32'h0, rd, err);
        chk(rd, 32'hA5A55A5A);
        run(CMD_GET_INPUT, PORT_TEMP_FIRST, BANK_ONE, 32'h0, 1'b1, 1'b0, STATUS_OK);
        host.apb(1'b0, REG_ACCU, 32'h0, rd, err);
        chk(rd, {20'h0, tmp[11:0]});
        run(CMD_GET_INPUT, PORT_ALL, BANK_TWO, 32'h0, 1'b0, 1'b0, STATUS_OK);
        run(CMD_GET_INPUT, 8'h05, BANK_ONE, 32'h0, 1'b0, 1'b0, STATUS_BAD_TYPE);
        run(8'h13, 8'h00, BANK_ZERO, 32'h0, 1'b0, 1'b0, STATUS_BAD_CMD);
        v = {24'h0, ~gp_m};
        run(CMD_SET_OUTPUT, PORT_ALL, BANK_TWO, v, 1'b0, 1'b1, STATUS_BAD_CHECKSUM);
        chk({24'h0, gp_outputs}, {24'h0, gp_m});
        host.apb(1'b0, 8'h24, 32'h0, rd, err);
        chk({31'h0, err}, 32'h1);
        stop_test();
    end
endmodule : tb_io_port_command_unit
bind iopc_top iopc_asserts u_asserts (.clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .gp_outputs_o(gp_outputs_o), .pullup_enable_o(pullup_enable_o));
